/* logic/amon_pkg.sv */
// alarm monitor package: register map, field positions, alarm codes, timing
// assumes a 100 MHz core clock and a 32-bit apb register port
package amon_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned RESET_HOLD_MS = 10;
  localparam int unsigned RESET_HOLD_CYCLES = RESET_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
  localparam int unsigned LIMITED_OVL_S = 5;
  localparam logic [15:0] LIMITED_OVL_MS = 16'(LIMITED_OVL_S * 1000);
  localparam logic [15:0] OVL_TIME_RST = 16'h1388;
  localparam logic [1:0] POR_SETTLE = 2'h3;

  // register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_OVL_TIME = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  // control fields
  localparam int unsigned CTRL_RUNSEL_LO = 0;
  localparam int unsigned CTRL_POR_EN = 2;
  localparam int unsigned CTRL_EXT_ASSIGN = 3;
  localparam int unsigned CTRL_RST_ASSIGN = 4;
  localparam int unsigned CTRL_MON_RESET = 5;
  localparam logic [5:0] CTRL_RST = 6'h04;

  // status fields
  localparam int unsigned ST_CODE_LO = 0;
  localparam int unsigned ST_ACTIVE = 8;
  localparam int unsigned ST_RESETTABLE = 9;
  localparam int unsigned ST_DRIVE_EN = 10;
  localparam int unsigned ST_HOLD_REL = 11;
  localparam int unsigned ST_BRAKE = 12;

  typedef enum logic [1:0] {
    AMON_RUN_OFF = 2'b00,
    AMON_RUN_ON = 2'b01,
    AMON_RUN_COMBINED = 2'b10
  } amon_runsel_t;

  // pin vector positions
  localparam int unsigned PIN_W = 15;
  localparam int unsigned P_OVERCURRENT = 0;
  localparam int unsigned P_OVERHEAT = 1;
  localparam int unsigned P_OVERVOLT = 2;
  localparam int unsigned P_UNDERVOLT = 3;
  localparam int unsigned P_SENSOR_LOST = 4;
  localparam int unsigned P_CONT_OVERLOAD = 5;
  localparam int unsigned P_LIMIT_OVERLOAD = 6;
  localparam int unsigned P_SHAFT_LOCKED = 7;
  localparam int unsigned P_OVERSPEED = 8;
  localparam int unsigned P_NVM_FAULT = 9;
  localparam int unsigned P_RUN_SWITCH = 10;
  localparam int unsigned P_FWD = 11;
  localparam int unsigned P_REV = 12;
  localparam int unsigned P_EXT_FAULT = 13;
  localparam int unsigned P_MOTOR_STOPPED = 14;

  // alarm codes as shown on the panel
  localparam logic [7:0] AL_NONE = 8'h00;
  localparam logic [7:0] AL_OVERCURRENT = 8'h20;
  localparam logic [7:0] AL_OVERHEAT = 8'h21;
  localparam logic [7:0] AL_OVERVOLT = 8'h22;
  localparam logic [7:0] AL_UNDERVOLT = 8'h25;
  localparam logic [7:0] AL_SENSOR = 8'h28;
  localparam logic [7:0] AL_OVERLOAD = 8'h30;
  localparam logic [7:0] AL_OVERSPEED = 8'h31;
  localparam logic [7:0] AL_NVM = 8'h41;
  localparam logic [7:0] AL_SENSOR_POR = 8'h42;
  localparam logic [7:0] AL_RUN_POR = 8'h46;
  localparam logic [7:0] AL_EXT_STOP = 8'h6e;
endpackage : amon_pkg

/* logic/amon_pin_if.sv */
// interface: conditioned pin levels and reset-input release pulse
// assumes one core clock shared by producer and consumer
`timescale 1ns/1ps
`default_nettype none
interface amon_pin_if;
  logic [amon_pkg::PIN_W-1:0] pins;
  logic reset_release;
  modport src (output pins, output reset_release);
  modport dst (input pins, input reset_release);
endinterface : amon_pin_if
`default_nettype wire

/* logic/amon_pin_cond.sv */
// pin conditioner: two-flop synchronisers and reset-input qualification
// assumes all pins asynchronous to core_clk_i
`timescale 1ns/1ps
`default_nettype none
module amon_pin_cond #(
  parameter int unsigned RESET_HOLD = amon_pkg::RESET_HOLD_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [amon_pkg::PIN_W-1:0] pins_raw_i,
  input wire logic alarm_reset_raw_i,
  amon_pin_if.src pin_o
);
  logic [amon_pkg::PIN_W:0] sync_a;
  logic [amon_pkg::PIN_W:0] sync_b;
  logic rst_prev;
  logic [23:0] hold_cnt;
  logic release_q;
  logic next_rst_prev;
  logic [23:0] next_hold_cnt;
  logic next_release;
  logic rst_lvl;

  assign rst_lvl = sync_b[amon_pkg::PIN_W];

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {alarm_reset_raw_i, pins_raw_i};
      sync_b <= sync_a;
    end
  end

  always_comb begin
    next_rst_prev = rst_lvl;
    next_hold_cnt = hold_cnt;
    next_release = 1'b0;
    if (rst_lvl) begin
      if (hold_cnt < 24'(RESET_HOLD)) begin
        next_hold_cnt = hold_cnt + 24'h000001;
      end
    end else begin
      next_hold_cnt = 24'h000000;
      // release only on the off edge after a long enough pulse
      if (rst_prev && hold_cnt >= 24'(RESET_HOLD)) begin
        next_release = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rst_prev <= 1'b0;
      hold_cnt <= 24'h000000;
      release_q <= 1'b0;
    end else begin
      rst_prev <= next_rst_prev;
      hold_cnt <= next_hold_cnt;
      release_q <= next_release;
    end
  end

  assign pin_o.pins = sync_b[amon_pkg::PIN_W-1:0];
  assign pin_o.reset_release = release_q;
endmodule : amon_pin_cond
`default_nettype wire

/* logic/amon_alarm_top.sv */
// motor driver alarm monitor: detection, latching and stop sequencing
// assumes fault sense pins are active-high levels from analog comparators,
// the external fault input is high while healthy, apb master on core_clk_i
// Functional notes
// - overcurrent raises 20, power cycle only
// - overheat above threshold raises 21
// - overvoltage raises 22, resettable
// - undervoltage raises 25
// - sensor loss while running raises 28
// - sustained overload or locked shaft raises 30
// - limited overload within min(5 s, time)
// - overspeed raises 31
// - memory fault raises 41, not resettable
// - sensor lost at power-on raises 42
// - switch mode, run switch at power-on
// - power-on run check only when enabled
// - external fault input low raises 6e
// - external stop only when assigned
// - clear by monitor command or assigned input
// - alarm coasts, then releases holding
// - external stop brakes, then releases holding
// - reset on off edge, not while running
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module amon_alarm_top #(
  parameter int unsigned MS_TICK = amon_pkg::MS_CYCLES,
  parameter int unsigned RESET_HOLD = amon_pkg::RESET_HOLD_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic overcurrent_i,
  input wire logic overheat_i,
  input wire logic overvolt_i,
  input wire logic undervolt_i,
  input wire logic sensor_lost_i,
  input wire logic cont_overload_i,
  input wire logic limit_overload_i,
  input wire logic shaft_locked_i,
  input wire logic overspeed_i,
  input wire logic nvm_fault_i,
  input wire logic run_switch_i,
  input wire logic forward_run_in_i,
  input wire logic reverse_run_in_i,
  input wire logic external_fault_in_i,
  input wire logic alarm_reset_i,
  input wire logic motor_stopped_i,
  output logic drive_enable_o,
  output logic coast_o,
  output logic brake_o,
  output logic hold_release_o,
  output logic alarm_o,
  output logic [7:0] alarm_code_o
);
  amon_pin_if pin_bus ();

  amon_pin_cond #(.RESET_HOLD(RESET_HOLD)) u_cond (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .pins_raw_i({motor_stopped_i, external_fault_in_i, reverse_run_in_i, forward_run_in_i,
                 run_switch_i, nvm_fault_i, overspeed_i, shaft_locked_i, limit_overload_i,
                 cont_overload_i, sensor_lost_i, undervolt_i, overvolt_i, overheat_i,
                 overcurrent_i}),
    .alarm_reset_raw_i(alarm_reset_i),
    .pin_o(pin_bus.src)
  );

  function automatic logic resettable(input logic [7:0] code);
    resettable = (code != amon_pkg::AL_OVERCURRENT) && (code != amon_pkg::AL_NVM);
  endfunction : resettable

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] reg_addr);
    addr_hit = (a == reg_addr);
  endfunction : addr_hit

  logic [amon_pkg::PIN_W-1:0] p;
  assign p = pin_bus.pins;

  // register state
  logic [5:0] ctrl;
  logic [15:0] ovl_time;
  logic [5:0] next_ctrl;
  logic [15:0] next_ovl_time;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic access;
  logic [31:0] status_word;
  amon_pkg::amon_runsel_t run_sel;

  assign run_sel = amon_pkg::amon_runsel_t'(ctrl[amon_pkg::CTRL_RUNSEL_LO +: 2]);
  // only one wait state, keeps the bus answer a fixed two access cycles
  assign access = psel && penable && !pready;

  always_comb begin
    next_ctrl = ctrl;
    next_ovl_time = ovl_time;
    next_prdata = prdata;
    next_pready = access;
    next_pslverr = 1'b0;
    next_ctrl[amon_pkg::CTRL_MON_RESET] = 1'b0;
    if (access) begin
      next_prdata = 32'h00000000;
      if (addr_hit(paddr, amon_pkg::ADDR_CTRL)) begin
        next_prdata = {26'h0000000, ctrl};
        if (pwrite) begin
          next_ctrl = pwdata[5:0];
        end
      end else if (addr_hit(paddr, amon_pkg::ADDR_OVL_TIME)) begin
        next_prdata = {16'h0000, ovl_time};
        if (pwrite) begin
          next_ovl_time = pwdata[15:0];
        end
      end else if (addr_hit(paddr, amon_pkg::ADDR_STATUS)) begin
        next_prdata = status_word;
      end else begin
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      ctrl <= amon_pkg::CTRL_RST;
      ovl_time <= amon_pkg::OVL_TIME_RST;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      ovl_time <= next_ovl_time;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // power-on capture once the synchronisers hold real pin levels
  logic [1:0] por_cnt;
  logic por_done;
  logic por_sensor;
  logic por_run;
  logic [1:0] next_por_cnt;
  logic next_por_done;
  logic next_por_sensor;
  logic next_por_run;
  logic run_signal;

  always_comb begin
    case (run_sel)
      amon_pkg::AMON_RUN_OFF: run_signal = p[amon_pkg::P_RUN_SWITCH];
      amon_pkg::AMON_RUN_ON: run_signal = p[amon_pkg::P_FWD] || p[amon_pkg::P_REV];
      amon_pkg::AMON_RUN_COMBINED: run_signal = p[amon_pkg::P_FWD] || p[amon_pkg::P_REV];
      default: run_signal = p[amon_pkg::P_FWD] || p[amon_pkg::P_REV];
    endcase
  end

  always_comb begin
    next_por_cnt = por_cnt;
    next_por_done = por_done;
    next_por_sensor = 1'b0;
    next_por_run = 1'b0;
    if (!por_done) begin
      next_por_cnt = por_cnt + 2'h1;
      if (por_cnt == amon_pkg::POR_SETTLE) begin
        next_por_done = 1'b1;
        next_por_sensor = p[amon_pkg::P_SENSOR_LOST];
        // run_signal already follows the mode, covering all three cases
        next_por_run = run_signal && ctrl[amon_pkg::CTRL_POR_EN];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      por_cnt <= 2'h0;
      por_done <= 1'b0;
      por_sensor <= 1'b0;
      por_run <= 1'b0;
    end else begin
      por_cnt <= next_por_cnt;
      por_done <= next_por_done;
      por_sensor <= next_por_sensor;
      por_run <= next_por_run;
    end
  end

  // overload timing in millisecond ticks
  logic [23:0] tick_cnt;
  logic [15:0] ovl_ms;
  logic [23:0] next_tick_cnt;
  logic [15:0] next_ovl_ms;
  logic heavy;
  logic any_ovl;
  logic [15:0] ovl_limit;
  logic ovl_trip;

  assign heavy = p[amon_pkg::P_LIMIT_OVERLOAD] || p[amon_pkg::P_SHAFT_LOCKED];
  assign any_ovl = heavy || p[amon_pkg::P_CONT_OVERLOAD];
  assign ovl_limit = (heavy && ovl_time > amon_pkg::LIMITED_OVL_MS) ?
                     amon_pkg::LIMITED_OVL_MS : ovl_time;
  assign ovl_trip = any_ovl && (ovl_ms >= ovl_limit);

  always_comb begin
    next_tick_cnt = 24'h000000;
    next_ovl_ms = 16'h0000;
    if (any_ovl) begin
      next_tick_cnt = tick_cnt + 24'h000001;
      next_ovl_ms = ovl_ms;
      if (tick_cnt >= 24'(MS_TICK - 1)) begin
        next_tick_cnt = 24'h000000;
        if (ovl_ms != 16'hffff) begin
          next_ovl_ms = ovl_ms + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      tick_cnt <= 24'h000000;
      ovl_ms <= 16'h0000;
    end else begin
      tick_cnt <= next_tick_cnt;
      ovl_ms <= next_ovl_ms;
    end
  end

  // detection, highest priority first
  logic det_any;
  logic [7:0] det_code;
  always_comb begin
    det_any = 1'b1;
    det_code = amon_pkg::AL_NONE;
    if (p[amon_pkg::P_OVERCURRENT]) begin
      det_code = amon_pkg::AL_OVERCURRENT;
    end else if (p[amon_pkg::P_NVM_FAULT]) begin
      det_code = amon_pkg::AL_NVM;
    end else if (p[amon_pkg::P_OVERHEAT]) begin
      det_code = amon_pkg::AL_OVERHEAT;
    end else if (p[amon_pkg::P_OVERVOLT]) begin
      det_code = amon_pkg::AL_OVERVOLT;
    end else if (p[amon_pkg::P_UNDERVOLT]) begin
      det_code = amon_pkg::AL_UNDERVOLT;
    end else if (p[amon_pkg::P_SENSOR_LOST] && !p[amon_pkg::P_MOTOR_STOPPED]) begin
      det_code = amon_pkg::AL_SENSOR;
    end else if (ovl_trip) begin
      det_code = amon_pkg::AL_OVERLOAD;
    end else if (p[amon_pkg::P_OVERSPEED]) begin
      det_code = amon_pkg::AL_OVERSPEED;
    end else if (por_sensor) begin
      det_code = amon_pkg::AL_SENSOR_POR;
    end else if (por_run) begin
      det_code = amon_pkg::AL_RUN_POR;
    end else if (ctrl[amon_pkg::CTRL_EXT_ASSIGN] && !p[amon_pkg::P_EXT_FAULT]) begin
      det_code = amon_pkg::AL_EXT_STOP;
    end else begin
      det_any = 1'b0;
    end
  end

  // alarm latch and stop sequencing
  logic active;
  logic [7:0] code;
  logic next_active;
  logic [7:0] next_code;
  logic clear_req;
  logic next_drive;
  logic next_coast;
  logic next_brake;
  logic next_hold_rel;

  assign clear_req = ctrl[amon_pkg::CTRL_MON_RESET] ||
                     (ctrl[amon_pkg::CTRL_RST_ASSIGN] && pin_bus.reset_release &&
                      !run_signal);

  always_comb begin
    next_active = active;
    next_code = code;
    if (!active) begin
      if (det_any) begin
        next_active = 1'b1;
        next_code = det_code;
      end
    end else if (clear_req && resettable(code)) begin
      // a fault still present in the clear cycle wins
      next_active = det_any;
      next_code = det_any ? det_code : amon_pkg::AL_NONE;
    end
    next_drive = por_done && !next_active;
    next_coast = next_active && next_code != amon_pkg::AL_EXT_STOP &&
                 !p[amon_pkg::P_MOTOR_STOPPED];
    next_brake = next_active && next_code == amon_pkg::AL_EXT_STOP &&
                 !p[amon_pkg::P_MOTOR_STOPPED];
    next_hold_rel = next_active && p[amon_pkg::P_MOTOR_STOPPED];
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      active <= 1'b0;
      code <= amon_pkg::AL_NONE;
      drive_enable_o <= 1'b0;
      coast_o <= 1'b0;
      brake_o <= 1'b0;
      hold_release_o <= 1'b0;
    end else begin
      active <= next_active;
      code <= next_code;
      drive_enable_o <= next_drive;
      coast_o <= next_coast;
      brake_o <= next_brake;
      hold_release_o <= next_hold_rel;
    end
  end

  assign alarm_o = active;
  assign alarm_code_o = code;

  always_comb begin
    status_word = 32'h00000000;
    status_word[amon_pkg::ST_CODE_LO +: 8] = code;
    status_word[amon_pkg::ST_ACTIVE] = active;
    status_word[amon_pkg::ST_RESETTABLE] = active && resettable(code);
    status_word[amon_pkg::ST_DRIVE_EN] = drive_enable_o;
    status_word[amon_pkg::ST_HOLD_REL] = hold_release_o;
    status_word[amon_pkg::ST_BRAKE] = brake_o;
  end
endmodule : amon_alarm_top
`default_nettype wire

/* tb/amon_alarm_asserts.sv */
// checker for the alarm monitor top: apb timing, alarm latching, stop outputs
// assumes one core clock and the synchronous active-low reset of the top
`timescale 1ns/1ps
`default_nettype none
module amon_alarm_asserts (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic overcurrent_i,
  input wire logic drive_enable_o,
  input wire logic coast_o,
  input wire logic brake_o,
  input wire logic hold_release_o,
  input wire logic alarm_o,
  input wire logic [7:0] alarm_code_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_fatal;
    alarm_o && (alarm_code_o == amon_pkg::AL_OVERCURRENT || alarm_code_o == amon_pkg::AL_NVM);
  endsequence
  apb_ready_a: assert property (s_setup ##1 s_access |=> pready)
    else $error("pready missing in second access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  drive_off_a: assert property (alarm_o |-> !drive_enable_o)
    else $error("drive enabled during alarm");
  code_valid_a: assert property (alarm_o == (alarm_code_o != amon_pkg::AL_NONE))
    else $error("alarm flag and code disagree");
  code_hold_a: assert property (alarm_o && $past(alarm_o) |-> $stable(alarm_code_o))
    else $error("latched code changed");
  fatal_hold_a: assert property (s_fatal |=> alarm_o && $stable(alarm_code_o))
    else $error("unresettable alarm cleared");
  oc_raise_a: assert property ($rose(overcurrent_i) && !alarm_o |-> ##[1:5] alarm_o)
    else $error("overcurrent not latched");
  coast_only_a: assert property (coast_o |-> alarm_o && alarm_code_o != amon_pkg::AL_EXT_STOP)
    else $error("coast without plain alarm");
  brake_ext_a: assert property (brake_o |-> alarm_code_o == amon_pkg::AL_EXT_STOP)
    else $error("brake without external stop");
  hold_rel_a: assert property (hold_release_o |-> alarm_o && !coast_o && !brake_o)
    else $error("holding released out of order");
endmodule : amon_alarm_asserts
bind amon_alarm_top amon_alarm_asserts chk_u (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .overcurrent_i(overcurrent_i),
  .drive_enable_o(drive_enable_o), .coast_o(coast_o), .brake_o(brake_o),
  .hold_release_o(hold_release_o), .alarm_o(alarm_o), .alarm_code_o(alarm_code_o)
);
`default_nettype wire

/* tb/amon_ctrl_model.sv */
// controller model: drives the alarm reset input as a held pulse
// assumes the caller runs on the core clock of the monitor
`timescale 1ns/1ps
`default_nettype none
module amon_ctrl_model (
  input wire logic core_clk_i,
  output logic alarm_reset_o
);
  initial alarm_reset_o = 1'b0;
  // whole edge counts so the monitor sees a clean level
  task automatic pulse(input int unsigned cyc);
    @(posedge core_clk_i);
    alarm_reset_o <= 1'b1;
    repeat (cyc) @(posedge core_clk_i);
    alarm_reset_o <= 1'b0;
  endtask : pulse
endmodule : amon_ctrl_model
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the alarm monitor top
// assumes short counts: 10 cycles per ms and a 20-cycle reset-input hold
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {int unsigned pin; logic [7:0] code; logic res;} amon_row_t;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready, pslverr, e, ar, drv, cst, brk, hrel, alm;
  logic [7:0] code;
  logic [14:0] pv = 15'h2000; // external fault input healthy, motor moving
  int failures = 0;
  int tests_run = 0;
  int n;
  amon_row_t rows [11] = '{'{0, 8'h20, 1'b0}, '{1, 8'h21, 1'b1}, '{2, 8'h22, 1'b1},
    '{3, 8'h25, 1'b1}, '{4, 8'h28, 1'b1}, '{5, 8'h30, 1'b1}, '{6, 8'h30, 1'b1},
    '{7, 8'h30, 1'b1}, '{8, 8'h31, 1'b1}, '{9, 8'h41, 1'b0}, '{13, 8'h6e, 1'b1}};
  // power-on rows: pin held at power-on, control written right after release, expected code
  int unsigned por_pin [5] = '{4, 10, 11, 12, 10};
  logic [31:0] por_ctl [5] = '{32'h04, 32'h04, 32'h05, 32'h06, 32'h00};
  logic [7:0] por_code [5] = '{8'h42, 8'h46, 8'h46, 8'h46, 8'h00};

  always #5 clk = ~clk;

  amon_alarm_top #(.MS_TICK(10), .RESET_HOLD(20)) dut_u (
    .core_clk_i(clk), .nrst_i(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .overcurrent_i(pv[0]), .overheat_i(pv[1]), .overvolt_i(pv[2]), .undervolt_i(pv[3]),
    .sensor_lost_i(pv[4]), .cont_overload_i(pv[5]), .limit_overload_i(pv[6]),
    .shaft_locked_i(pv[7]), .overspeed_i(pv[8]), .nvm_fault_i(pv[9]),
    .run_switch_i(pv[10]), .forward_run_in_i(pv[11]), .reverse_run_in_i(pv[12]),
    .external_fault_in_i(pv[13]), .alarm_reset_i(ar), .motor_stopped_i(pv[14]),
    .drive_enable_o(drv), .coast_o(cst), .brake_o(brk), .hold_release_o(hrel),
    .alarm_o(alm), .alarm_code_o(code)
  );
  amon_ctrl_model ctl_u (.core_clk_i(clk), .alarm_reset_o(ar));

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    // a bus that never answers counts against the run
    if (pready !== 1'b1) failures++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_al(input logic l, input int lim);
    n = 0;
    while (alm !== l && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_al

  task automatic boot();
    nrst <= 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (10) @(posedge clk);
  endtask : boot

  // ext stop and reset input assigned, overload time 3 ms
  task automatic setup();
    apb(1'b1, 12'h000, 32'h1c);
    apb(1'b1, 12'h004, 32'h3);
  endtask : setup

  task automatic flip(input int unsigned p);
    @(posedge clk);
    pv[p] <= ~pv[p];
  endtask : flip

  task automatic wrap_up();
    if (failures == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  initial begin
    #900_000;
    failures++;
    wrap_up();
  end

  initial begin
    boot();
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl reset", q, 32'h04);
    apb(1'b0, 12'h004, 32'h0);
    chk("ovl reset", q, 32'h1388);
    apb(1'b0, 12'h008, 32'h0);
    chk("status reset", q, 32'h400);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped err", 32'(e), 32'h1);
    chk("unmapped data", q, 32'h0);
    setup();
    foreach (rows[i]) begin
      flip(rows[i].pin);
      wait_al(1'b1, 100);
      chk("code", 32'(code), 32'(rows[i].code));
      chk("drive", 32'(drv), 32'h0);
      repeat (2) @(posedge clk);
      chk("brake", 32'(brk), 32'(rows[i].code == 8'h6e));
      chk("coast", 32'(cst), 32'(rows[i].code != 8'h6e));
      apb(1'b0, 12'h008, 32'h0);
      chk("resettable", 32'(q[9]), 32'(rows[i].res));
      flip(rows[i].pin);
      repeat (5) @(posedge clk);
      apb(1'b1, 12'h000, 32'h3c);
      repeat (10) @(posedge clk);
      chk("cleared", 32'(alm), 32'(!rows[i].res));
      if (!rows[i].res) begin
        boot();
        setup();
      end
    end
    flip(5);
    repeat (15) @(posedge clk);
    chk("ovl early", 32'(alm), 32'h0);
    wait_al(1'b1, 40);
    chk("ovl due", 32'(alm), 32'h1);
    flip(5);
    apb(1'b1, 12'h000, 32'h3c);
    wait_al(1'b0, 20);
    // detection time above the cap: limited overload still trips at 5 s
    apb(1'b1, 12'h004, 32'h1770);
    flip(6);
    wait_al(1'b1, 60000);
    chk("ovl cap", 32'(n > 49900 && n < 50100), 32'h1);
    flip(6);
    apb(1'b1, 12'h000, 32'h3c);
    wait_al(1'b0, 20);
    apb(1'b1, 12'h004, 32'h3);
    apb(1'b1, 12'h000, 32'h14);
    flip(13);
    repeat (20) @(posedge clk);
    chk("ext unassigned", 32'(alm), 32'h0);
    flip(13);
    repeat (5) @(posedge clk);
    apb(1'b1, 12'h000, 32'h1c);
    flip(2);
    wait_al(1'b1, 20);
    flip(14);
    flip(2);
    repeat (5) @(posedge clk);
    chk("hold release", 32'(hrel), 32'h1);
    ctl_u.pulse(5);
    repeat (10) @(posedge clk);
    chk("short pulse", 32'(alm), 32'h1);
    flip(10);
    ctl_u.pulse(25);
    repeat (10) @(posedge clk);
    chk("run blocks", 32'(alm), 32'h1);
    flip(10);
    ctl_u.pulse(25);
    wait_al(1'b0, 20);
    chk("input clear", 32'(alm), 32'h0);
    foreach (por_pin[i]) begin
      pv[por_pin[i]] <= 1'b1;
      nrst <= 1'b0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      // mode write must land before the power-on capture, four edges after release
      apb(1'b1, 12'h000, por_ctl[i]);
      wait_al(1'b1, 20);
      chk("power-on code", 32'(code), 32'(por_code[i]));
      flip(por_pin[i]);
      setup();
      apb(1'b1, 12'h000, 32'h3c);
      wait_al(1'b0, 20);
      chk("power-on clear", 32'(alm), 32'h0);
    end
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
